/* File: pkg/sync_qual_pkg.sv */
// Purpose: constants, register map and carriers of the sync permit qualifier
// Assumes: one clock, 50 MHz; program cycle of one setting step
// Notes: offsets are byte addresses of aligned 32-bit words
package sync_qual_pkg;
	// ------------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------------
	localparam int NUM_STAGES = 3;
	localparam int TIMER_W = 19;
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROG_CYCLE_NS = 5000000;
	localparam int CYCLE_CLKS = PROG_CYCLE_NS / CLK_PERIOD_NS;
	localparam int CYCLE_W = 18;
	localparam logic [TIMER_W-1:0] DELAY_RST = 19'h0000A;
	localparam logic [TIMER_W-1:0] PULSE_RST = 19'h0000A;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PULSE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;

	// control word fields
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_GATE_LSB = 3;
	localparam int CTRL_SIDE_BIT = 6;
	localparam int CTRL_BEHAV_LSB = 8;
	localparam int CTRL_FORCE_EN_BIT = 10;
	localparam logic [31:0] CTRL_WMASK = 32'h0000077F;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] MODE_WMASK = 32'h00000007;
	localparam logic [31:0] FORCE_WMASK = 32'h00000007;
	localparam logic [31:0] TIMER_WMASK = 32'h0007FFFF;
	localparam logic [31:0] IRQ_WMASK = 32'h0000003F;
	// status word: permit bits, blocked bits, settings-open bit
	localparam int STAT_PERMIT_LSB = 0;
	localparam int STAT_BLOCKED_LSB = 3;
	localparam int STAT_OPEN_BIT = 6;
	localparam int IRQ_W = 2 * NUM_STAGES;

	// ------------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_ON = 3'h0,
		MODE_BLOCKED = 3'h1,
		MODE_TEST = 3'h2,
		MODE_TEST_BLOCKED = 3'h3,
		MODE_OFF = 3'h4
	} node_operating_mode_t;

	typedef enum logic [1:0] {
		BEH_CONT = 2'h0,
		BEH_DELAYED_CONT = 2'h1,
		BEH_DELAYED_PULSE = 2'h2
	} permit_behaviour_t;

	// force codes: odd selects blocked, even nonzero selects ok
	localparam logic [2:0] FORCE_NORMAL = 3'h0;
	localparam logic [2:0] FORCE_STAGE_STEP = 3'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DELAY = 5'h02,
		ST_OK = 5'h04,
		ST_DONE = 5'h08,
		ST_BLOCKED = 5'h10
	} stage_state_t;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_STAGES-1:0] sync_cond;
		logic [NUM_STAGES-1:0] stage_check_request_in;
	} stage_in_t;

	typedef struct packed {
		logic [NUM_STAGES-1:0] sync_permit_out;
		logic [NUM_STAGES-1:0] blocked;
	} qual_out_t;
endpackage : sync_qual_pkg

/* File: design/stage_qualifier.sv */
// Purpose: one stage's permit sequencing with delay and pulse timers
// Assumes: i_tick is a one-cycle program-cycle strobe
// Notes: outputs decode the state flop directly
module stage_qualifier #(
	parameter int TW = sync_qual_pkg::TIMER_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic i_active,
	input wire logic i_sync,
	input wire logic i_block,
	input wire logic [1:0] i_behav,
	input wire logic [TW-1:0] i_delay,
	input wire logic [TW-1:0] i_pulse,
	output logic o_permit,
	output logic o_blocked
);
	sync_qual_pkg::stage_state_t state_ff, nxt_state;
	logic [TW-1:0] cnt_ff, nxt_cnt;
	logic cond;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// any drop of the condition returns to idle, which restarts timers
	always_comb begin
		cond = i_active & i_sync;
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			sync_qual_pkg::ST_IDLE: begin
				nxt_cnt = '0;
				if (cond) begin
					if (i_behav == sync_qual_pkg::BEH_DELAYED_CONT) begin
						nxt_state = sync_qual_pkg::ST_DELAY;
					end else if (i_block) begin
						nxt_state = sync_qual_pkg::ST_BLOCKED;
					end else begin
						nxt_state = sync_qual_pkg::ST_OK;
					end
				end
			end
			sync_qual_pkg::ST_DELAY: begin
				if (!cond) begin
					nxt_state = sync_qual_pkg::ST_IDLE;
				end else if (cnt_ff >= i_delay) begin
					nxt_cnt = '0;
					nxt_state = i_block ? sync_qual_pkg::ST_BLOCKED : sync_qual_pkg::ST_OK;
				end else if (i_tick) begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			sync_qual_pkg::ST_OK: begin
				if (!cond) begin
					nxt_state = sync_qual_pkg::ST_IDLE;
				end else if (i_block) begin
					nxt_state = sync_qual_pkg::ST_BLOCKED;
				end else if (i_behav == sync_qual_pkg::BEH_DELAYED_PULSE) begin
					if (cnt_ff >= i_pulse) begin
						nxt_state = sync_qual_pkg::ST_DONE;
					end else if (i_tick) begin
						nxt_cnt = cnt_ff + 1'b1;
					end
				end
			end
			// pulse spent or blocked: hold until the condition goes away
			sync_qual_pkg::ST_DONE, sync_qual_pkg::ST_BLOCKED: begin
				if (!cond) begin
					nxt_state = sync_qual_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = sync_qual_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= sync_qual_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// timer register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign o_permit = (state_ff == sync_qual_pkg::ST_OK);
	assign o_blocked = (state_ff == sync_qual_pkg::ST_BLOCKED);
endmodule : stage_qualifier

/* File: design/sync_check_output_qualifier.sv */
// Purpose: qualify the sync permit of three synchrocheck stages
// Assumes: comparison results and start requests synchronous to i_clk
// Notes: registers on Avalon-MM with one wait state per access
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
module sync_check_output_qualifier #(
	parameter int CYCLE_CLKS = sync_qual_pkg::CYCLE_CLKS,
	parameter int TW = sync_qual_pkg::TIMER_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [sync_qual_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [1:0] i_aux_sync_cfg,
	input wire sync_qual_pkg::stage_in_t i_stage,
	input wire logic i_block,
	output sync_qual_pkg::qual_out_t o_qual,
	output logic o_line_is_measured,
	output logic o_test_active,
	output logic o_irq
);
	localparam int NS = sync_qual_pkg::NUM_STAGES;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic ack_ff;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] ctrl_ff, mode_ff, force_ff, delay_ff, pulse_ff;
	logic [sync_qual_pkg::IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_event;
	logic [sync_qual_pkg::CYCLE_W-1:0] cyc_cnt_ff;
	logic tick_ff, block_smp_ff;
	logic open_cfg, wr_take, rd_take;
	logic [31:0] be_mask;
	logic [NS-1:0] st_permit, st_blocked, fin_permit, fin_blocked;
	logic [NS-1:0] permit_ff, blocked_ff, out_permit_ff, out_blocked_ff;
	logic [NS-1:0] stage_en, gate_on_start, active;
	sync_qual_pkg::node_operating_mode_t mode;
	logic mode_block, mode_test, mode_off, force_en;
	logic [1:0] behav;

	// ------------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------------
	assign mode = sync_qual_pkg::node_operating_mode_t'(mode_ff[2:0]);
	assign stage_en = ctrl_ff[sync_qual_pkg::CTRL_EN_LSB +: NS];
	assign gate_on_start = ctrl_ff[sync_qual_pkg::CTRL_GATE_LSB +: NS];
	assign behav = ctrl_ff[sync_qual_pkg::CTRL_BEHAV_LSB +: 2];
	assign force_en = ctrl_ff[sync_qual_pkg::CTRL_FORCE_EN_BIT];
	assign o_line_is_measured = ctrl_ff[sync_qual_pkg::CTRL_SIDE_BIT];
	assign open_cfg = |i_aux_sync_cfg;
	// blocked-type modes act like a permanent blocking input
	assign mode_block = (mode == sync_qual_pkg::MODE_BLOCKED) ||
		(mode == sync_qual_pkg::MODE_TEST_BLOCKED);
	assign mode_test = (mode == sync_qual_pkg::MODE_TEST) ||
		(mode == sync_qual_pkg::MODE_TEST_BLOCKED);
	assign mode_off = (mode == sync_qual_pkg::MODE_OFF);
	assign o_test_active = mode_test;

	// ------------------------------------------------------------------
	// avalon slave handshake
	// ------------------------------------------------------------------
	// one wait state lets read data come from a flop
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
	assign wr_take = i_avs_write & ack_ff;
	assign rd_take = i_avs_read & ~ack_ff;
	assign o_avs_readdata = rdata_ff;

	// byte lanes to a bit mask
	always_comb begin
		be_mask = '0;
		for (int b = 0; b < 4; b++) begin
			be_mask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
		end
	end

	// acknowledge pulses high for one cycle per request
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
		end
	end

	// read mux; settings read zero while no aux channel is in sync mode
	always_comb begin
		nxt_rdata = '0;
		if (i_avs_address == sync_qual_pkg::OFS_CTRL) begin
			nxt_rdata = open_cfg ? ctrl_ff : '0;
		end else if (i_avs_address == sync_qual_pkg::OFS_MODE) begin
			nxt_rdata = open_cfg ? mode_ff : '0;
		end else if (i_avs_address == sync_qual_pkg::OFS_FORCE) begin
			nxt_rdata = open_cfg ? force_ff : '0;
		end else if (i_avs_address == sync_qual_pkg::OFS_DELAY) begin
			nxt_rdata = open_cfg ? delay_ff : '0;
		end else if (i_avs_address == sync_qual_pkg::OFS_PULSE) begin
			nxt_rdata = open_cfg ? pulse_ff : '0;
		end else if (i_avs_address == sync_qual_pkg::OFS_STATUS) begin
			nxt_rdata[sync_qual_pkg::STAT_PERMIT_LSB +: NS] = permit_ff;
			nxt_rdata[sync_qual_pkg::STAT_BLOCKED_LSB +: NS] = blocked_ff;
			nxt_rdata[sync_qual_pkg::STAT_OPEN_BIT] = open_cfg;
		end else if (i_avs_address == sync_qual_pkg::OFS_IRQ_STAT) begin
			nxt_rdata[sync_qual_pkg::IRQ_W-1:0] = irq_stat_ff;
		end else if (i_avs_address == sync_qual_pkg::OFS_IRQ_MASK) begin
			nxt_rdata[sync_qual_pkg::IRQ_W-1:0] = irq_mask_ff;
		end
	end

	// read data register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= '0;
		end else if (rd_take) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------------
	// setting registers
	// ------------------------------------------------------------------
	// writes to settings are dropped while the settings are hidden
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= sync_qual_pkg::CTRL_RST;
			mode_ff <= {29'h0, sync_qual_pkg::MODE_ON};
			force_ff <= {29'h0, sync_qual_pkg::FORCE_NORMAL};
			delay_ff <= {13'h0, sync_qual_pkg::DELAY_RST};
			pulse_ff <= {13'h0, sync_qual_pkg::PULSE_RST};
		end else if (wr_take && open_cfg) begin
			if (i_avs_address == sync_qual_pkg::OFS_CTRL) begin
				ctrl_ff <= (ctrl_ff & ~be_mask) |
					(i_avs_writedata & be_mask & sync_qual_pkg::CTRL_WMASK);
			end else if (i_avs_address == sync_qual_pkg::OFS_MODE) begin
				if (i_avs_byteenable[0] && (i_avs_writedata[2:0] <= sync_qual_pkg::MODE_OFF)) begin
					mode_ff <= i_avs_writedata & sync_qual_pkg::MODE_WMASK;
				end
			end else if (i_avs_address == sync_qual_pkg::OFS_FORCE) begin
				force_ff <= (force_ff & ~be_mask) |
					(i_avs_writedata & be_mask & sync_qual_pkg::FORCE_WMASK);
			end else if (i_avs_address == sync_qual_pkg::OFS_DELAY) begin
				delay_ff <= (delay_ff & ~be_mask) |
					(i_avs_writedata & be_mask & sync_qual_pkg::TIMER_WMASK);
			end else if (i_avs_address == sync_qual_pkg::OFS_PULSE) begin
				pulse_ff <= (pulse_ff & ~be_mask) |
					(i_avs_writedata & be_mask & sync_qual_pkg::TIMER_WMASK);
			end
		end
	end

	// ------------------------------------------------------------------
	// program cycle tick and blocking sample
	// ------------------------------------------------------------------
	// tick fires once per program cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cyc_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (cyc_cnt_ff == sync_qual_pkg::CYCLE_W'(CYCLE_CLKS - 1)) begin
			cyc_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	// blocking is frozen for a whole program cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			block_smp_ff <= 1'b0;
		end else if (tick_ff) begin
			block_smp_ff <= i_block;
		end
	end

	// ------------------------------------------------------------------
	// stages
	// ------------------------------------------------------------------
	// off mode parks every stage in idle
	assign active = stage_en & (~gate_on_start | i_stage.stage_check_request_in) &
		{NS{~mode_off}};

	generate
		for (genvar s = 0; s < NS; s++) begin : g_stage
			logic frc_hit;
			stage_qualifier #(
				.TW(TW)
			) u_stage (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_tick(tick_ff),
				.i_active(active[s]),
				.i_sync(i_stage.sync_cond[s]),
				.i_block(block_smp_ff | mode_block),
				.i_behav(behav),
				.i_delay(delay_ff[TW-1:0]),
				.i_pulse(pulse_ff[TW-1:0]),
				.o_permit(st_permit[s]),
				.o_blocked(st_blocked[s])
			);
			// force codes 2s+1 (blocked) and 2s+2 (ok) belong to stage s
			assign frc_hit = force_en && (force_ff[2:0] != sync_qual_pkg::FORCE_NORMAL) &&
				(((force_ff[2:0] - 3'h1) >> 1) == 3'(s));
			assign fin_permit[s] = frc_hit ? ~force_ff[0] : st_permit[s];
			assign fin_blocked[s] = frc_hit ? force_ff[0] : st_blocked[s];
		end
	endgenerate

	// ------------------------------------------------------------------
	// outputs and status
	// ------------------------------------------------------------------
	// test modes show the result in status but keep the outputs quiet
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			permit_ff <= '0;
			blocked_ff <= '0;
			out_permit_ff <= '0;
			out_blocked_ff <= '0;
		end else begin
			permit_ff <= fin_permit;
			blocked_ff <= fin_blocked;
			out_permit_ff <= fin_permit & {NS{~mode_test}};
			out_blocked_ff <= fin_blocked & {NS{~mode_test}};
		end
	end
	// one driver for the whole carrier
	assign o_qual = {out_permit_ff, out_blocked_ff};

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	// rising permit and blocked flags are the events
	assign irq_event = {fin_blocked & ~blocked_ff, fin_permit & ~permit_ff};

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_stat_ff <= '0;
		end else if (wr_take && (i_avs_address == sync_qual_pkg::OFS_IRQ_STAT)) begin
			irq_stat_ff <= (irq_stat_ff & ~(i_avs_writedata[sync_qual_pkg::IRQ_W-1:0] &
				be_mask[sync_qual_pkg::IRQ_W-1:0])) | irq_event;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_event;
		end
	end

	// mask register, not hidden by the settings gate
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_mask_ff <= '0;
		end else if (wr_take && (i_avs_address == sync_qual_pkg::OFS_IRQ_MASK) &&
				i_avs_byteenable[0]) begin
			irq_mask_ff <= i_avs_writedata[sync_qual_pkg::IRQ_W-1:0];
		end
	end

	assign o_irq = |(irq_stat_ff & irq_mask_ff);
endmodule : sync_check_output_qualifier

/* File: testbench/sync_qual_assertions.sv */
// Purpose: port checks of the sync permit qualifier
// Assumes: small CYCLE_CLKS in simulation
// Notes: forcing while blocking is held high is not exercised
module sync_qual_assertions #(
	parameter int CYCLE_CLKS = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [sync_qual_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [1:0] i_aux_sync_cfg,
	input wire sync_qual_pkg::stage_in_t i_stage,
	input wire logic i_block,
	input wire sync_qual_pkg::qual_out_t o_qual,
	input wire logic o_line_is_measured,
	input wire logic o_test_active,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] blk_cnt_ff;
	logic ctrl_wr;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// control write completing this cycle
	assign ctrl_wr = i_avs_write & ~o_avs_waitrequest & (i_avs_address == sync_qual_pkg::OFS_CTRL);
	// saturating run length of blocking, so long holds stay cheap
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) blk_cnt_ff <= 8'h00;
		else if (!i_block) blk_cnt_ff <= 8'h00;
		else if (blk_cnt_ff != 8'hFF) blk_cnt_ff <= blk_cnt_ff + 8'h01;
	end
	property p_closed_zero;
		(i_avs_read && !o_avs_waitrequest && i_aux_sync_cfg == 2'h0 && $past(i_aux_sync_cfg) == 2'h0
			&& i_avs_address <= 8'h10) |-> o_avs_readdata == 32'h0;
	endproperty
	a_closed_zero: assert property (p_closed_zero) else $error("closed settings read nonzero");
	property p_exclusive;
		(o_qual.sync_permit_out & o_qual.blocked) == 3'h0;
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("permit and blocked together");
	property p_block_kills;
		blk_cnt_ff > CYCLE_CLKS + 3 |-> o_qual.sync_permit_out == 3'h0;
	endproperty
	a_block_kills: assert property (p_block_kills) else $error("permit under held blocking");
	sequence s_test3;
		o_test_active [*3];
	endsequence
	property p_test_quiet;
		s_test3 |-> o_qual == '0;
	endproperty
	a_test_quiet: assert property (p_test_quiet) else $error("outputs active in test mode");
	property p_cond_drop;
		$fell(i_stage.sync_cond[0]) |-> ##[1:3] !o_qual.sync_permit_out[0];
	endproperty
	a_cond_drop: assert property (p_cond_drop) else $error("permit outlived sync");
	property p_side_by_write;
		$changed(o_line_is_measured) |-> $past(ctrl_wr);
	endproperty
	a_side_by_write: assert property (p_side_by_write) else $error("side moved without write");
	property p_write_wait;
		$rose(i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
	endproperty
	a_write_wait: assert property (p_write_wait) else $error("write wait state wrong");
	property p_read_wait;
		$rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
	property p_irq_fall;
		$fell(o_irq) |-> $past(i_avs_write);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
	c_permit: cover property ($rose(o_qual.sync_permit_out[0]));
	c_blocked: cover property ($rose(o_qual.blocked[0]));
	c_irq: cover property ($rose(o_irq));
endmodule : sync_qual_assertions

bind sync_check_output_qualifier sync_qual_assertions #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_aux_sync_cfg(i_aux_sync_cfg), .i_stage(i_stage),
	.i_block(i_block), .o_qual(o_qual), .o_line_is_measured(o_line_is_measured),
	.o_test_active(o_test_active), .o_irq(o_irq));

/* File: testbench/far_side_model.sv */
// Purpose: far side: sync results, start requests, blocking matrix
// Assumes: commands from the bench
// Notes: levels launch one edge late, like a matrix output stage
module far_side_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_cond,
	input wire logic [2:0] i_start,
	input wire logic i_blk,
	output sync_qual_pkg::stage_in_t o_stage,
	output logic o_block
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered levels, quiet during reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_stage <= '0;
			o_block <= 1'b0;
		end else begin
			o_stage.sync_cond <= i_cond;
			o_stage.stage_check_request_in <= i_start;
			o_block <= i_blk;
		end
	end
endmodule : far_side_model

/* File: testbench/sync_check_output_qualifier_tb_top.sv */
// Purpose: directed register and stage tests
// Assumes: program cycle shortened to 4 clocks
// Notes: one wait state bus, bus waits bounded only by the watchdog
module sync_check_output_qualifier_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, rd, wr, waitreq, blk, block, line_m, test_a, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [1:0] aux;
	logic [2:0] cond, start, sb;
	sync_qual_pkg::stage_in_t stage;
	sync_qual_pkg::qual_out_t qual;
	int mismatches = 0;
	int compares = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	sync_check_output_qualifier #(.CYCLE_CLKS(4)) dut (.i_clk(clk), .i_rst(rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_aux_sync_cfg(aux), .i_stage(stage), .i_block(block), .o_qual(qual),
		.o_line_is_measured(line_m), .o_test_active(test_a), .o_irq(irq));
	far_side_model fsm (.i_clk(clk), .i_rst(rst), .i_cond(cond), .i_start(start), .i_blk(blk),
		.o_stage(stage), .o_block(block));
	task end_sim;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task wcyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wcyc
	// request held until waitrequest is sampled low
	// no cycle limit here: only the watchdog may end a hung wait
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task bw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : bw
	task br(input logic [7:0] a, input string nm, input logic [31:0] ex);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, ex, q);
	endtask : br
	// watchdog, run needs about 360 clocks
	initial begin
		wcyc(5000);
		mismatches++;
		$display("mismatch watchdog expected done seen timeout");
		end_sim();
	end
	// main sequence
	initial begin
		clk = 0; rst = 1; rd = 0; wr = 0; addr = 8'h00; wdata = 32'h0;
		aux = 2'h0; cond = 3'h0; start = 3'h0; blk = 0;
		wcyc(10);
		rst <= 1'b0;
		@(posedge clk);
		bw(sync_qual_pkg::OFS_CTRL, 32'h1);
		br(sync_qual_pkg::OFS_CTRL, "ctrl closed", 32'h0);
		br(sync_qual_pkg::OFS_DELAY, "delay closed", 32'h0);
		aux <= 2'h2;
		br(sync_qual_pkg::OFS_CTRL, "ctrl", sync_qual_pkg::CTRL_RST);
		br(sync_qual_pkg::OFS_MODE, "mode", 32'h0);
		br(sync_qual_pkg::OFS_FORCE, "force", 32'h0);
		br(sync_qual_pkg::OFS_DELAY, "delay", 32'(sync_qual_pkg::DELAY_RST));
		br(sync_qual_pkg::OFS_PULSE, "pulse", 32'(sync_qual_pkg::PULSE_RST));
		br(sync_qual_pkg::OFS_STATUS, "status", 32'h40);
		br(8'h20, "unmapped", 32'h0);
		for (int m = 0; m < 5; m++) begin
			bw(sync_qual_pkg::OFS_MODE, 32'(m));
			br(sync_qual_pkg::OFS_MODE, "mode", 32'(m));
		end
		bw(sync_qual_pkg::OFS_MODE, 32'h5);
		br(sync_qual_pkg::OFS_MODE, "mode bad", 32'h4);
		bw(sync_qual_pkg::OFS_CTRL, 32'h1);
		cond <= 3'h1;
		wcyc(6);
		chk("permit off", 32'h0, 32'(qual.sync_permit_out));
		bw(sync_qual_pkg::OFS_MODE, 32'h0);
		wcyc(5);
		chk("permit cont", 32'h1, 32'(qual.sync_permit_out));
		cond <= 3'h0;
		wcyc(5);
		chk("permit drop", 32'h0, 32'(qual.sync_permit_out));
		$display("test regs and modes done");
		bw(sync_qual_pkg::OFS_CTRL, 32'h0);
		cond <= 3'h7;
		wcyc(6);
		chk("permit disabled", 32'h0, 32'(qual.sync_permit_out));
		bw(sync_qual_pkg::OFS_CTRL, 32'h12);
		wcyc(5);
		chk("permit no start", 32'h0, 32'(qual.sync_permit_out));
		start <= 3'h2;
		wcyc(5);
		chk("permit start", 32'h2, 32'(qual.sync_permit_out));
		bw(sync_qual_pkg::OFS_CTRL, 32'h02);
		start <= 3'h0;
		wcyc(5);
		chk("permit always", 32'h2, 32'(qual.sync_permit_out));
		cond <= 3'h0;
		bw(sync_qual_pkg::OFS_CTRL, 32'h40);
		chk("line measured", 32'h1, 32'(line_m));
		bw(sync_qual_pkg::OFS_CTRL, 32'h0);
		chk("bus measured", 32'h0, 32'(line_m));
		$display("test enable gating side done");
		bw(sync_qual_pkg::OFS_DELAY, 32'h3);
		bw(sync_qual_pkg::OFS_CTRL, 32'h101);
		cond <= 3'h1;
		wcyc(10);
		cond <= 3'h0;
		wcyc(2);
		cond <= 3'h1;
		wcyc(8);
		chk("delay restart", 32'h0, 32'(qual.sync_permit_out));
		wcyc(16);
		chk("delay done", 32'h1, 32'(qual.sync_permit_out));
		cond <= 3'h0;
		bw(sync_qual_pkg::OFS_PULSE, 32'h2);
		bw(sync_qual_pkg::OFS_CTRL, 32'h201);
		cond <= 3'h1;
		wcyc(5);
		chk("pulse on", 32'h1, 32'(qual.sync_permit_out));
		wcyc(20);
		chk("pulse end", 32'h0, 32'(qual.sync_permit_out));
		cond <= 3'h0;
		$display("test timers done");
		bw(sync_qual_pkg::OFS_CTRL, 32'h1);
		blk <= 1'b1;
		wcyc(10);
		cond <= 3'h1;
		wcyc(12);
		chk("blocked permit", 32'h0, 32'(qual.sync_permit_out));
		chk("blocked out", 32'h1, 32'(qual.blocked));
		cond <= 3'h0;
		blk <= 1'b0;
		wcyc(12);
		cond <= 3'h1;
		wcyc(6);
		chk("permit pre block", 32'h1, 32'(qual.sync_permit_out));
		blk <= 1'b1;
		wcyc(12);
		chk("permit reset", 32'h0, 32'(qual.sync_permit_out));
		blk <= 1'b0;
		cond <= 3'h0;
		wcyc(6);
		bw(sync_qual_pkg::OFS_MODE, 32'h2);
		cond <= 3'h1;
		wcyc(6);
		chk("test active", 32'h1, 32'(test_a));
		chk("test outputs", 32'h0, 32'(qual));
		br(sync_qual_pkg::OFS_STATUS, "status test", 32'h41);
		cond <= 3'h0;
		bw(sync_qual_pkg::OFS_MODE, 32'h0);
		$display("test blocking and test mode done");
		bw(sync_qual_pkg::OFS_IRQ_STAT, 32'h3F);
		bw(sync_qual_pkg::OFS_IRQ_MASK, 32'h0);
		cond <= 3'h1;
		wcyc(6);
		br(sync_qual_pkg::OFS_IRQ_STAT, "irq stat", 32'h1);
		chk("irq masked", 32'h0, 32'(irq));
		bw(sync_qual_pkg::OFS_IRQ_MASK, 32'h1);
		chk("irq on", 32'h1, 32'(irq));
		bw(sync_qual_pkg::OFS_IRQ_STAT, 32'h1);
		chk("irq cleared", 32'h0, 32'(irq));
		cond <= 3'h0;
		bw(sync_qual_pkg::OFS_CTRL, 32'h407);
		for (int c = 1; c < 7; c++) begin
			sb = 3'h1 << ((c - 1) / 2);
			bw(sync_qual_pkg::OFS_FORCE, 32'(c));
			wcyc(3);
			chk("force permit", (c % 2 == 0) ? 32'(sb) : 32'h0, 32'(qual.sync_permit_out));
			chk("force blocked", (c % 2 == 1) ? 32'(sb) : 32'h0, 32'(qual.blocked));
		end
		bw(sync_qual_pkg::OFS_CTRL, 32'h7);
		bw(sync_qual_pkg::OFS_FORCE, 32'h2);
		wcyc(3);
		chk("force disabled", 32'h0, 32'(qual.sync_permit_out));
		$display("test irq and force done");
		end_sim();
	end
endmodule : sync_check_output_qualifier_tb_top
